// File: rtl/id_words.sv
// identification words 53, 65-82 served over axi4-lite
`include "id_words_consts.svh"
`default_nettype none
module id_words
	import id_words_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// link state and speed from the phy
	input  wire logic        LINK_UP,
	input  wire logic [2:0]  LINK_SPEED,
	// axi4-lite write address
	input  wire logic        S_AXI_AWVALID,
	output var  logic        S_AXI_AWREADY,
	input  wire logic [11:0] S_AXI_AWADDR,
	// axi4-lite write data
	input  wire logic        S_AXI_WVALID,
	output var  logic        S_AXI_WREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	// axi4-lite write response
	output var  logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	output var  logic [1:0]  S_AXI_BRESP,
	// axi4-lite read address
	input  wire logic        S_AXI_ARVALID,
	output var  logic        S_AXI_ARREADY,
	input  wire logic [11:0] S_AXI_ARADDR,
	// axi4-lite read data
	output var  logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output var  logic [31:0] S_AXI_RDATA,
	output var  logic [1:0]  S_AXI_RRESP
);

	state_t s_r;
	state_t s_nxt;

	// link state seen last cycle, for renegotiation edge
	logic link_up_r;
	always_ff @(posedge CLK) begin
		if (RST) begin
			link_up_r <= 1'b0;
		end else begin
			link_up_r <= LINK_UP;
		end
	end

	logic reneg;
	assign reneg = LINK_UP && !link_up_r;

	// identification word table, word n at byte 4*n
	logic [15:0] id_word [65:82];
	logic [15:0] w76;
	logic [15:0] w77;

	// model-dependent rate support bits of word 76, negotiated rate bits of word 77
	always_comb begin
		w76 = `W76_BASE;
		w76[`W76_GEN2_BIT] = s_r.ctrl[`CTRL_GEN2_BIT];
		w76[`W76_GEN3_BIT] = s_r.ctrl[`CTRL_GEN3_BIT];
		w77 = `W77_BASE;
		w77[`W77_SPD_LSB +: 3] = s_r.speed;
	end

	genvar gi;
	generate
		for (gi = 65; gi <= 82; gi++) begin : g_word
			always_comb begin
				case (gi)
					65: id_word[gi] = `W65_VALUE;
					66: id_word[gi] = `W66_VALUE;
					67: id_word[gi] = `W67_VALUE;
					68: id_word[gi] = `W68_VALUE;
					69: id_word[gi] = `W69_VALUE;
					75: id_word[gi] = `W75_VALUE;
					76: id_word[gi] = w76;
					77: id_word[gi] = w77;
					78: id_word[gi] = `W78_VALUE;
					79: id_word[gi] = `W79_VALUE;
					80: id_word[gi] = `W80_VALUE;
					81: id_word[gi] = `W81_VALUE;
					82: id_word[gi] = `W82_VALUE;
					default: id_word[gi] = 16'h0000;
				endcase
			end
		end
	endgenerate

	// read decode
	logic [31:0] rd_data;
	logic [1:0]  rd_resp;
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_resp = `RESP_OKAY;
		if (S_AXI_ARADDR[1:0] != 2'h0) begin
			rd_resp = `RESP_SLVERR;
		end else if (S_AXI_ARADDR == `ADDR_W53) begin
			rd_data = {16'h0000, `W53_VALUE};
		end else if (S_AXI_ARADDR >= `ADDR_FIRST && S_AXI_ARADDR <= `ADDR_LAST) begin
			rd_data = {16'h0000, id_word[7'(S_AXI_ARADDR[11:2])]};
		end else if (S_AXI_ARADDR == `ADDR_CTRL) begin
			rd_data = {30'h0, s_r.ctrl};
		end else if (S_AXI_ARADDR == `ADDR_STAT) begin
			rd_data = {16'h0, s_r.reneg_cnt, 4'h0, LINK_UP, s_r.speed};
		end else begin
			rd_resp = `RESP_SLVERR;
		end
	end

	// next state
	always_comb begin
		s_nxt = s_r;
		// speed latched at each link-up edge
		if (reneg) begin
			s_nxt.speed = LINK_SPEED;
			s_nxt.reneg_cnt = s_r.reneg_cnt + 8'h01;
		end
		// write address and data taken in either order
		if (S_AXI_AWVALID && s_r.wr.awready) begin
			s_nxt.wr.aw_ok = 1'b1;
			s_nxt.wr.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s_r.wr.wready) begin
			s_nxt.wr.w_ok = 1'b1;
			s_nxt.wr.wdata = S_AXI_WDATA;
			s_nxt.wr.wstrb = S_AXI_WSTRB;
		end
		if (s_r.wr.aw_ok && s_r.wr.w_ok) begin
			s_nxt.wr.aw_ok = 1'b0;
			s_nxt.wr.w_ok = 1'b0;
			s_nxt.wr.bvalid = 1'b1;
			if (s_r.wr.awaddr == `ADDR_CTRL) begin
				s_nxt.wr.bresp = `RESP_OKAY;
				if (s_r.wr.wstrb[0]) begin
					s_nxt.ctrl = s_r.wr.wdata[1:0];
				end
			end else begin
				s_nxt.wr.bresp = `RESP_SLVERR;
			end
		end
		if (s_r.wr.bvalid && S_AXI_BREADY) begin
			s_nxt.wr.bvalid = 1'b0;
		end
		// read channel
		case (s_r.rd)
			RD_IDLE: begin
				s_nxt.arready = 1'b1;
				if (S_AXI_ARVALID && s_r.arready) begin
					s_nxt.arready = 1'b0;
					s_nxt.rvalid = 1'b1;
					s_nxt.rdata = rd_data;
					s_nxt.rresp = rd_resp;
					s_nxt.rd = RD_RESP;
				end
			end
			RD_RESP: begin
				if (S_AXI_RREADY) begin
					s_nxt.rvalid = 1'b0;
					s_nxt.arready = 1'b1;
					s_nxt.rd = RD_IDLE;
				end
			end
			default: begin
				s_nxt.rd = RD_IDLE;
			end
		endcase
		// readies kept in flops so the bus sees no logic path; reset clears them,
		// so nothing is taken before the second edge after release
		s_nxt.wr.awready = !s_nxt.wr.aw_ok && !s_nxt.wr.bvalid;
		s_nxt.wr.wready = !s_nxt.wr.w_ok && !s_nxt.wr.bvalid;
	end

	// state register
	always_ff @(posedge CLK) begin
		if (RST) begin
			s_r <= '0;
			s_r.rd <= RD_IDLE;
			s_r.ctrl <= `CTRL_RESET;
			s_r.speed <= `SPD_GEN1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flops
	assign S_AXI_AWREADY = s_r.wr.awready;
	assign S_AXI_WREADY  = s_r.wr.wready;
	assign S_AXI_BVALID  = s_r.wr.bvalid;
	assign S_AXI_BRESP   = s_r.wr.bresp;
	assign S_AXI_ARREADY = s_r.arready;
	assign S_AXI_RVALID  = s_r.rvalid;
	assign S_AXI_RDATA   = s_r.rdata;
	assign S_AXI_RRESP   = s_r.rresp;

	// constant words reach the bus unchanged
	AST_W53_VALID: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h0d4
		|=> S_AXI_RDATA == 32'h0000_0007) else $error("word 53 wrong");
	AST_W65_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h104
		|=> S_AXI_RDATA == 32'h0000_0078) else $error("word 65 wrong");
	AST_W66_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h108
		|=> S_AXI_RDATA == 32'h0000_0078) else $error("word 66 wrong");
	AST_W67_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h10c
		|=> S_AXI_RDATA == 32'h0000_0078) else $error("word 67 wrong");
	AST_W68_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h110
		|=> S_AXI_RDATA == 32'h0000_0078) else $error("word 68 wrong");
	AST_W69_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h114
		|=> S_AXI_RDATA == 32'h0000_0c08) else $error("word 69 wrong");
	AST_W75_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h12c
		|=> S_AXI_RDATA == 32'h0000_001f) else $error("word 75 wrong");
	AST_W78_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h138
		|=> S_AXI_RDATA == 32'h0000_0cde) else $error("word 78 wrong");
	AST_W79_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h13c
		|=> S_AXI_RDATA == 32'h0000_0040) else $error("word 79 wrong");
	AST_W80_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h140
		|=> S_AXI_RDATA == 32'h0000_03fc) else $error("word 80 wrong");
	AST_W81_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h144
		|=> S_AXI_RDATA == 32'h0000_0029) else $error("word 81 wrong");
	AST_W82_CONST: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h148
		|=> S_AXI_RDATA == 32'h0000_746b) else $error("word 82 wrong");

	// reserved words 70-74 read zero
	AST_RESERVED: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h118
		|=> S_AXI_RDATA == 32'h0000_0000) else $error("word 70 not zero");
	AST_RESERVED_HIGH: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= 12'h11c && S_AXI_ARADDR <= 12'h128
		|=> S_AXI_RDATA == 32'h0000_0000) else $error("words 71-74 not zero");

	// capability and speed words, fixed and variable parts as seen on the bus
	AST_W76_FIXED: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h130
		|=> (S_AXI_RDATA & 32'hffff_fff3) == 32'h0000_9702) else $error("word 76 fixed wrong");
	AST_W76_GEN1: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h130
		|=> S_AXI_RDATA[1] && S_AXI_RDATA[3:2] == $past(s_r.ctrl)) else $error("word 76 rates");
	AST_W77_HIGH: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h134
		|=> (S_AXI_RDATA & 32'hffff_fff1) == 32'h0000_0030) else $error("word 77 fixed wrong");
	AST_W77_SPEED: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h134
		|=> S_AXI_RDATA[3:1] == $past(s_r.speed)) else $error("word 77 speed wrong");

	// negotiated rate taken at each link-up edge
	sequence link_rise;
		!LINK_UP ##1 LINK_UP;
	endsequence
	AST_SPEED_LATCH: assert property (@(posedge CLK) disable iff (RST)
		link_rise |=> w77[3:1] == $past(LINK_SPEED))
		else $error("speed not latched");

	// read channel: one outstanding, answered next cycle, held until taken
	AST_RD_ANSWER: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	AST_RD_HOLD: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	AST_RD_ONE: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("second read accepted");
	AST_RD_SLVERR: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[1:0] != 2'h0
		|=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0000_0000) else $error("unaligned read");

	// write channel: both halves taken, answer two cycles later
	sequence aw_w_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence b_after_two;
		##2 S_AXI_BVALID;
	endsequence
	sequence refused_after_two;
		##2 S_AXI_BVALID && S_AXI_BRESP == 2'h2;
	endsequence
	AST_WR_ANSWER: assert property (@(posedge CLK) disable iff (RST)
		aw_w_taken |-> b_after_two)
		else $error("write not answered");
	AST_WR_REFUSED: assert property (@(posedge CLK) disable iff (RST)
		aw_w_taken ##0 S_AXI_AWADDR == 12'h104 |-> refused_after_two)
		else $error("write to constant word accepted");
	AST_B_HOLD: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write answer dropped");
	AST_B_DONE: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
		else $error("write answer not released");
	AST_WR_ONE: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("second write accepted");

endmodule : id_words
`default_nettype wire

// File: shared/id_words_consts.svh
// constants for identification data words 53 and 65 through 82
// Operation
// - word 65 reads 0078h, minimum multiword DMA cycle 120 ns
// - word 66 reads 0078h, recommended multiword DMA cycle 120 ns
// - word 67 reads 0078h, minimum PIO cycle without flow control
// - word 68 reads 0078h, minimum PIO cycle with IORDY flow control
// - word 69 reads 0c08h: buffer DMA commands, extended sector count
// - word 75 reads 001fh, queue depth minus one, upper bits zero
// - word 76 sets bits 15,12,10,9,8; bit 11 and reserved zero
// - word 76 bit 1 always set; bits 2,3 follow model rate support
// - word 77 bits 3-1 encode negotiated rate 011/010/001
// - word 77 sets bits 5 and 4; bits 15-6 read zero
// - word 78 reads 0cdeh, supported link features
// - word 79 reads 0040h, only setting preservation enabled
// - word 80 reads 03fch, word 81 reads 0029h
// - word 82 reads 746bh, command set support
// - word 53 bit 1 set, words 64-70 valid
`ifndef ID_WORDS_CONSTS_SVH
`define ID_WORDS_CONSTS_SVH
`define W53_VALUE      16'h0007
`define W65_VALUE      16'h0078
`define W66_VALUE      16'h0078
`define W67_VALUE      16'h0078
`define W68_VALUE      16'h0078
`define W69_VALUE      16'h0c08
`define W75_VALUE      16'h001f
`define W76_BASE       16'h9702
`define W76_GEN2_BIT   2
`define W76_GEN3_BIT   3
`define W77_BASE       16'h0030
`define W77_SPD_LSB    1
`define W78_VALUE      16'h0cde
`define W79_VALUE      16'h0040
`define W80_VALUE      16'h03fc
`define W81_VALUE      16'h0029
`define W82_VALUE      16'h746b
`define SPD_GEN1       3'h1
`define SPD_GEN2       3'h2
`define SPD_GEN3       3'h3
`define ADDR_W53       12'h0d4
`define ADDR_FIRST     12'h104
`define ADDR_LAST      12'h148
`define ADDR_CTRL      12'h200
`define ADDR_STAT      12'h204
`define CTRL_GEN2_BIT  0
`define CTRL_GEN3_BIT  1
`define CTRL_RESET     2'h3
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// File: shared/id_words_pkg.sv
// types for the identification data register bank
`default_nettype none
package id_words_pkg;
	typedef enum logic [1:0] {RD_IDLE, RD_RESP} rd_state_t;
	typedef struct packed {
		logic        aw_ok;
		logic        w_ok;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        awready;
		logic        wready;
	} wr_chan_t;
	typedef struct packed {
		wr_chan_t    wr;
		rd_state_t   rd;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [1:0]  ctrl;
		logic [2:0]  speed;
		logic [7:0]  reneg_cnt;
	} state_t;
endpackage : id_words_pkg
`default_nettype wire

// File: tb/id_words_tb_top.sv
// bench for the identification words bank
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module id_words_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, link_up, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [2:0]  link_speed;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	int          errors, comparisons, cycles;
	localparam logic [15:0] exp_w [18] = '{16'h0078, 16'h0078, 16'h0078, 16'h0078,
		16'h0c08, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h001f, 16'h970e, 16'h0032,
		16'h0cde, 16'h0040, 16'h03fc, 16'h0029, 16'h746b};
	id_words dut_u (.CLK(clk), .RST(rst), .LINK_UP(link_up), .LINK_SPEED(link_speed),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));
	phy_link_model phy_u (.clk(clk), .link_up(link_up), .link_speed(link_speed));
	// clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// print counts and verdict, then stop
	task automatic wrap_up();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			wrap_up();
		end
	end
	// one axi4-lite read, held until each channel is taken
	task automatic rd(input logic [11:0] a, output logic [31:0] dd, output logic [1:0] rr);
		int n;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 100) errors++;
		dd = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask : rd
	// one axi4-lite write, address and data offered together
	task automatic wr(input logic [11:0] a, input logic [31:0] dd, output logic [1:0] rr);
		int n;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= dd;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 100) errors++;
		rr = bresp;
		bready <= 1'b0;
	endtask : wr
	// main sequence
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, errors, comparisons, cycles} = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(12'h0d4, d, r);
		`CHK(d, 32'h0007)
		// every word 65..82 at its reset value
		for (int i = 0; i < 18; i++) begin
			rd(12'h104 + 12'(4 * i), d, r);
			`CHK(d, 32'(exp_w[i]))
			`CHK(r, 2'h0)
		end
		// model rate support bits in word 76
		for (int c = 0; c < 4; c++) begin
			wr(12'h200, 32'(c), r);
			`CHK(r, 2'h0)
			rd(12'h130, d, r);
			`CHK(d, 32'h9702 | 32'(c << 2))
		end
		// constant words refuse writes and keep their value
		wr(12'h104, 32'hffff, r);
		`CHK(r, 2'h2)
		rd(12'h104, d, r);
		`CHK(d, 32'h0078)
		// unmapped and unaligned reads
		rd(12'h300, d, r);
		`CHK(r, 2'h2)
		`CHK(d, 32'h0)
		rd(12'h106, d, r);
		`CHK(r, 2'h2)
		// renegotiation to each rate, back to back
		for (int s = 3; s > 0; s--) begin
			phy_u.renegotiate(3'(s));
			rd(12'h134, d, r);
			`CHK(d, 32'h0030 | 32'(s << 1))
		end
		// mid-run reset brings rate support back to its reset value
		wr(12'h200, 32'h0, r);
		`CHK(r, 2'h0)
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(12'h130, d, r);
		`CHK(d, 32'h970e)
		rd(12'h134, d, r);
		`CHK(d, 32'h0032)
		wrap_up();
	end
endmodule : id_words_tb_top
`default_nettype wire

// File: tb/phy_link_model.sv
// link partner model: drives link state and negotiated rate
`default_nettype none
module phy_link_model (
	// clock
	input  wire logic       clk,
	// link state and rate
	output var  logic       link_up,
	output var  logic [2:0] link_speed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] last_r;
	initial begin
		link_up = 1'b0;
		link_speed = 3'h1;
		last_r = 3'h1;
	end
	// drop the link, then come back up at a new rate
	task automatic renegotiate(input logic [2:0] spd);
		@(posedge clk);
		link_up <= 1'b0;
		link_speed <= ~last_r; // rate lines are not valid while down
		repeat (3) @(posedge clk);
		link_speed <= spd;
		last_r <= spd;
		@(posedge clk);
		link_up <= 1'b1;
	endtask : renegotiate
endmodule : phy_link_model
`default_nettype wire
